// ===== rtc_core.sv
/*
  Real-time clock core: oscillator halt flag, control registers, BCD time
  and calendar counters, periodic and alarm flags, interrupt pin routing
  and the 32 kHz clock output, behind an AXI4-Lite slave.
  Assumes osc_stopped is a level from an oscillator watchdog and that the
  alarm compare logic outside drives alarm_a_hit and alarm_b_hit.
*/
`include "rtc_regs.svh"
module rtc_core
  import rtc_pkg::*;
#(
  parameter int unsigned ADDR_W = 8,
  parameter int unsigned CLKS_PER_SEC = `RTC_CLKS_PER_SEC
)
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic [ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic osc_stopped,
  input wire logic alarm_a_hit,
  input wire logic alarm_b_hit,
  output logic irq_out_a_out,
  output logic irq_out_a_oe,
  output logic irq_out_b_out,
  output logic irq_out_b_oe,
  output logic clk32_out,
  output logic test_mode
);

  localparam logic [31:0] SEC_LAST = 32'(CLKS_PER_SEC - 1);
  localparam logic [31:0] SEC_HALF = 32'(CLKS_PER_SEC / 2);
  localparam logic [31:0] SEC_QUARTER = 32'(CLKS_PER_SEC / 4);
  localparam logic [11:0] CLK32_LAST = 12'(`RTC_CLK32_HALF - 1);

  // BCD increment of a two-digit value.
  function automatic rtc_byte_t bcd_inc(input rtc_byte_t v);
    if (v[3:0] == 4'h9)
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    else
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
  endfunction

  // Whether a byte address is mapped and word aligned.
  function automatic logic is_mapped(input logic [ADDR_W-1:0] a);
    logic [3:0] i;
    i = a[5:2];
    is_mapped = (a[1:0] == 2'h0) && (a[ADDR_W-1:6] == '0) &&
                ((i <= `RTC_IDX_TRIM) || (i == `RTC_IDX_CTRL1) || (i == `RTC_IDX_CTRL2));
  endfunction

  // A BCD year is leap when divisible by four, including 00.
  function automatic logic is_leap(input rtc_byte_t y);
    if (y[4])
      is_leap = (y[3:0] == 4'h2) || (y[3:0] == 4'h6);
    else
      is_leap = (y[3:0] == 4'h0) || (y[3:0] == 4'h4) || (y[3:0] == 4'h8);
  endfunction

  // Last day of a month in BCD.
  function automatic rtc_byte_t month_len(input rtc_byte_t m, input rtc_byte_t y);
    if (m == `RTC_MON_FEB)
      month_len = is_leap(y) ? `RTC_DAY_29 : `RTC_DAY_28;
    else if ((m == `RTC_MON_APR) || (m == `RTC_MON_JUN) ||
             (m == `RTC_MON_SEP) || (m == `RTC_MON_NOV))
      month_len = `RTC_DAY_30;
    else
      month_len = `RTC_DAY_31;
  endfunction

  // Next hour code; fmt24 high selects the 24-hour codes.
  function automatic rtc_byte_t hour_next(input rtc_byte_t h, input logic fmt24);
    if (fmt24)
      hour_next = (h == `RTC_HR24_LAST) ? `RTC_BCD_ZERO : bcd_inc(h);
    else if (h == `RTC_HR12_AM12)
      hour_next = `RTC_HR12_AM1;
    else if (h == `RTC_HR12_AM11)
      hour_next = `RTC_HR12_PM12;
    else if (h == `RTC_HR12_PM12)
      hour_next = `RTC_HR12_PM1;
    else if (h == `RTC_HR12_PM11)
      hour_next = `RTC_HR12_AM12;
    else
      hour_next = bcd_inc(h);
  endfunction

  rtc_byte_t seconds_count;
  rtc_byte_t minutes_count;
  rtc_byte_t hours_count;
  logic [2:0] weekday_bits;
  rtc_byte_t day_of_month_count;
  rtc_byte_t month_count;
  rtc_byte_t year_count;
  logic crystal_select;
  logic [6:0] trim_value;
  logic alarm_a_enable;
  logic alarm_b_enable;
  logic [1:0] irq_route_select;
  logic test_bit;
  logic [2:0] periodic_cycle_select;
  logic hour_format_select;
  logic clk_out_gate;
  logic osc_halt_flag;
  logic periodic_irq_flag;
  logic alarm_a_match_flag;
  logic alarm_b_match_flag;
  logic [31:0] sub_cnt;
  logic [11:0] cnt32;
  logic clk32_phase;
  logic aw_held;
  logic w_held;
  logic [ADDR_W-1:0] wr_addr;
  rtc_byte_t wr_byte;
  logic wr_lane;
  rtc_byte_t rd_byte;

  wire logic wr_fire = aw_held && w_held && !s_axi_bvalid;
  wire logic wr_ok = wr_fire && wr_lane && is_mapped(wr_addr);
  wire logic [3:0] wr_idx = wr_addr[5:2];
  wire logic wr_c2 = wr_ok && (wr_idx == `RTC_IDX_CTRL2);
  wire logic halt_force = osc_halt_flag || osc_stopped;
  wire logic sec_tick = !osc_stopped && (sub_cnt == SEC_LAST);
  wire logic wave1_low = sub_cnt < SEC_HALF;
  wire logic wave2_low = (sub_cnt < SEC_QUARTER) ||
                         ((sub_cnt >= SEC_HALF) && (sub_cnt < SEC_HALF + SEC_QUARTER));

  // Carry chain between the counters.
  wire logic sec_carry = sec_tick && (seconds_count == `RTC_BCD_59);
  wire logic min_carry = sec_carry && (minutes_count == `RTC_BCD_59);
  wire logic hour_last = hour_format_select ? (hours_count == `RTC_HR24_LAST) :
                         (hours_count == `RTC_HR12_PM11);
  wire logic hour_carry = min_carry && hour_last;
  wire logic day_carry = hour_carry &&
                         (day_of_month_count == month_len(month_count, year_count));
  wire logic month_carry = day_carry && (month_count == `RTC_MONTH_LAST);

  // Sub-second divider; it stops with the oscillator so time freezes.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || osc_stopped || sec_tick)
      sub_cnt <= '0;
    else
      sub_cnt <= sub_cnt + 32'h1;
  end

  // 32 kHz phase generator, derived from the system clock.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      cnt32 <= '0;
      clk32_phase <= 1'b0;
    end
    else if (!osc_stopped)
    begin
      if (cnt32 == CLK32_LAST)
      begin
        cnt32 <= '0;
        clk32_phase <= !clk32_phase;
      end
      else
        cnt32 <= cnt32 + 12'h1;
    end
  end

  // Write channel capture; address and data may arrive in either order.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      aw_held <= 1'b0;
      w_held <= 1'b0;
      wr_addr <= '0;
      wr_byte <= '0;
      wr_lane <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `RTC_RESP_OKAY;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        wr_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        wr_byte <= s_axi_wdata[7:0];
        wr_lane <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_held <= 1'b0;
        w_held <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= is_mapped(wr_addr) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;

  // Read mux; unused upper bits read zero.
  always_comb
  begin
    unique case (s_axi_araddr[5:2])
      `RTC_IDX_SEC: rd_byte = seconds_count;
      `RTC_IDX_MIN: rd_byte = minutes_count;
      `RTC_IDX_HOUR: rd_byte = hours_count;
      `RTC_IDX_WDAY: rd_byte = {5'h00, weekday_bits};
      `RTC_IDX_DAY: rd_byte = day_of_month_count;
      `RTC_IDX_MONTH: rd_byte = month_count;
      `RTC_IDX_YEAR: rd_byte = year_count;
      `RTC_IDX_TRIM: rd_byte = {crystal_select, trim_value};
      `RTC_IDX_CTRL1: rd_byte = {alarm_a_enable, alarm_b_enable, irq_route_select,
                                 test_bit, periodic_cycle_select};
      `RTC_IDX_CTRL2: rd_byte = {2'h0, hour_format_select, osc_halt_flag, clk_out_gate,
                                 periodic_irq_flag, alarm_a_match_flag && alarm_a_enable,
                                 alarm_b_match_flag && alarm_b_enable};
      default: rd_byte = 8'h00;
    endcase
  end

  // Read channel: one word per address, answered the cycle after it is taken.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= `RTC_RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= is_mapped(s_axi_araddr) ? {24'h000000, rd_byte} : 32'h00000000;
      s_axi_rresp <= is_mapped(s_axi_araddr) ? `RTC_RESP_OKAY : `RTC_RESP_SLVERR;
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // Halt flag; a stop in the clearing cycle wins so no halt goes unseen.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      osc_halt_flag <= 1'b1;
    else if (osc_stopped)
      osc_halt_flag <= 1'b1;
    else if (wr_c2)
      osc_halt_flag <= 1'b0;
  end

  // Control and trim bits, all cleared while the halt flag stands.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n || halt_force)
    begin
      crystal_select <= 1'b0;
      trim_value <= '0;
      alarm_a_enable <= 1'b0;
      alarm_b_enable <= 1'b0;
      irq_route_select <= '0;
      test_bit <= 1'b0;
      periodic_cycle_select <= '0;
      clk_out_gate <= 1'b0;
    end
    else if (wr_ok)
    begin
      if (wr_idx == `RTC_IDX_TRIM)
      begin
        crystal_select <= wr_byte[7];
        trim_value <= wr_byte[6:0];
      end
      if (wr_idx == `RTC_IDX_CTRL1)
      begin
        alarm_a_enable <= wr_byte[`RTC_C1_AEA];
        alarm_b_enable <= wr_byte[`RTC_C1_AEB];
        irq_route_select <= wr_byte[`RTC_C1_RT_HI:`RTC_C1_RT_LO];
        test_bit <= wr_byte[`RTC_C1_TEST];
        periodic_cycle_select <= wr_byte[`RTC_C1_CT_HI:0];
      end
      if (wr_idx == `RTC_IDX_CTRL2)
        clk_out_gate <= wr_byte[`RTC_C2_GATE];
    end
  end

  // Hour format is not among the bits the halt clears.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hour_format_select <= 1'b0;
    else if (wr_c2)
      hour_format_select <= wr_byte[`RTC_C2_FMT];
  end

  // Periodic flag: follows the waveform in pulse modes, sticky in level modes.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      periodic_irq_flag <= 1'b0;
    else
    begin
      unique case (rtc_pmode_t'(periodic_cycle_select))
        RTC_PM_OFF: periodic_irq_flag <= 1'b0;
        RTC_PM_LOW: periodic_irq_flag <= 1'b1;
        RTC_PM_P2HZ: periodic_irq_flag <= wave2_low;
        RTC_PM_P1HZ: periodic_irq_flag <= wave1_low;
        RTC_PM_SEC: periodic_irq_flag <= sec_tick ||
                      (periodic_irq_flag && !(wr_c2 && !wr_byte[`RTC_C2_PIRQ]));
        RTC_PM_MIN: periodic_irq_flag <= sec_carry ||
                      (periodic_irq_flag && !(wr_c2 && !wr_byte[`RTC_C2_PIRQ]));
        RTC_PM_HOUR: periodic_irq_flag <= min_carry ||
                      (periodic_irq_flag && !(wr_c2 && !wr_byte[`RTC_C2_PIRQ]));
        RTC_PM_MONTH: periodic_irq_flag <= day_carry ||
                      (periodic_irq_flag && !(wr_c2 && !wr_byte[`RTC_C2_PIRQ]));
      endcase
    end
  end

  // Alarm flags; a match in the clearing cycle wins, writing one does nothing.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      alarm_a_match_flag <= 1'b0;
      alarm_b_match_flag <= 1'b0;
    end
    else
    begin
      alarm_a_match_flag <= alarm_a_enable && (alarm_a_hit ||
        (alarm_a_match_flag && !(wr_c2 && !wr_byte[`RTC_C2_AFA])));
      alarm_b_match_flag <= alarm_b_enable && (alarm_b_hit ||
        (alarm_b_match_flag && !(wr_c2 && !wr_byte[`RTC_C2_AFB])));
    end
  end

  // Time counters; a software write beats a tick in the same cycle.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      seconds_count <= `RTC_BCD_ZERO;
      minutes_count <= `RTC_BCD_ZERO;
      hours_count <= `RTC_BCD_ZERO;
    end
    else
    begin
      if (wr_ok && (wr_idx == `RTC_IDX_SEC))
        seconds_count <= wr_byte & `RTC_MASK_SEC;
      else if (sec_tick)
        seconds_count <= sec_carry ? `RTC_BCD_ZERO : bcd_inc(seconds_count);
      if (wr_ok && (wr_idx == `RTC_IDX_MIN))
        minutes_count <= wr_byte & `RTC_MASK_SEC;
      else if (sec_carry)
        minutes_count <= min_carry ? `RTC_BCD_ZERO : bcd_inc(minutes_count);
      if (wr_ok && (wr_idx == `RTC_IDX_HOUR))
        hours_count <= wr_byte & `RTC_MASK_HOUR;
      else if (min_carry)
        hours_count <= hour_next(hours_count, hour_format_select);
    end
  end

  // Calendar counters; impossible values written by software are not repaired.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      weekday_bits <= '0;
      day_of_month_count <= `RTC_DAY_FIRST;
      month_count <= `RTC_DAY_FIRST;
      year_count <= `RTC_BCD_ZERO;
    end
    else
    begin
      if (wr_ok && (wr_idx == `RTC_IDX_WDAY))
        weekday_bits <= wr_byte[2:0];
      else if (hour_carry)
        weekday_bits <= (weekday_bits >= `RTC_WDAY_LAST) ? 3'h0 : weekday_bits + 3'h1;
      if (wr_ok && (wr_idx == `RTC_IDX_DAY))
        day_of_month_count <= wr_byte & `RTC_MASK_DAY;
      else if (hour_carry)
        day_of_month_count <= day_carry ? `RTC_DAY_FIRST : bcd_inc(day_of_month_count);
      if (wr_ok && (wr_idx == `RTC_IDX_MONTH))
        month_count <= wr_byte & `RTC_MASK_MONTH;
      else if (day_carry)
        month_count <= month_carry ? `RTC_DAY_FIRST : bcd_inc(month_count);
      if (wr_ok && (wr_idx == `RTC_IDX_YEAR))
        year_count <= wr_byte;
      else if (month_carry)
        year_count <= (year_count == `RTC_YEAR_LAST) ? `RTC_BCD_ZERO : bcd_inc(year_count);
    end
  end

  // Interrupt routing onto the two open-drain pins; B also carries the clock.
  logic route_a;
  logic route_b;
  always_comb
  begin
    route_a = alarm_a_match_flag ||
              (!irq_route_select[0] && alarm_b_match_flag) ||
              (!irq_route_select[1] && periodic_irq_flag);
    route_b = (irq_route_select[0] && alarm_b_match_flag) ||
              (irq_route_select[1] && periodic_irq_flag);
  end

  // Pin drivers are registered so the pads see no decode glitches.
  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      irq_out_a_oe <= 1'b0;
      irq_out_b_oe <= 1'b0;
      clk32_out <= 1'b0;
    end
    else
    begin
      irq_out_a_oe <= route_a && !halt_force;
      irq_out_b_oe <= route_b || (!clk_out_gate && !clk32_phase);
      clk32_out <= !clk_out_gate && clk32_phase;
    end
  end

  assign irq_out_a_out = 1'b0;
  assign irq_out_b_out = 1'b0;
  assign test_mode = test_bit;

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);

  sequence s_sec_wrap;
    sec_tick && (seconds_count == `RTC_BCD_59) && !wr_ok;
  endsequence
  sequence s_day_wrap;
    day_carry && !wr_ok;
  endsequence

  AST_HALT_SET: assert property (osc_stopped |=> osc_halt_flag[*2])
    else $error("halt flag not set after oscillator stop");
  AST_HALT_FORCE: assert property (osc_halt_flag |-> (trim_value == 7'h00)
    && !alarm_a_enable && !clk_out_gate && (periodic_cycle_select == 3'h0))
    else $error("control bits not forced while halted");
  AST_HALT_PINS: assert property (osc_halt_flag |=> !irq_out_a_oe)
    else $error("interrupt A driven while halted");
  AST_HALT_CLEAR: assert property (wr_c2 && !osc_stopped ##1 !osc_stopped
    |-> !osc_halt_flag)
    else $error("halt flag not cleared by control write");
  AST_CLK_GATE: assert property (clk_out_gate |=> !clk32_out)
    else $error("clock output active while gated");
  AST_PIRQ_SET: assert property ((periodic_cycle_select == 3'h4) && sec_tick
    && !halt_force |=> periodic_irq_flag)
    else $error("periodic flag missed a second event");
  AST_PIRQ_CLR: assert property ((periodic_cycle_select == 3'h4) && wr_c2
    && !wr_byte[`RTC_C2_PIRQ] && !sec_tick |=> !periodic_irq_flag)
    else $error("periodic flag not cleared");
  AST_ALARM_SET: assert property (alarm_a_enable && alarm_a_hit
    |=> alarm_a_match_flag)
    else $error("alarm flag not set on match");
  AST_ALARM_KEEP: assert property (alarm_a_match_flag && alarm_a_enable && wr_c2
    && wr_byte[`RTC_C2_AFA] && !halt_force |=> alarm_a_match_flag)
    else $error("write of one changed alarm flag");
  AST_ALARM_OFF: assert property (!$past(alarm_b_enable) |-> !alarm_b_match_flag)
    else $error("disabled alarm shows a match");
  AST_SEC_WRAP: assert property (s_sec_wrap |=> (seconds_count == `RTC_BCD_ZERO)
    && (minutes_count != $past(minutes_count)))
    else $error("seconds wrap did not carry");
  AST_DAY_WRAP: assert property (s_day_wrap |=>
    (day_of_month_count == `RTC_DAY_FIRST) && (weekday_bits != $past(weekday_bits)))
    else $error("day wrap did not carry");
  AST_WDAY_RANGE: assert property (hour_carry && (weekday_bits == `RTC_WDAY_LAST)
    && !wr_ok |=> weekday_bits == 3'h0)
    else $error("weekday did not wrap at six");

endmodule

// ===== rtc_osc_model.sv
/*
  Far-side model: oscillator watchdog level and alarm compare pulses.
  Assumes its tasks are called just after a rising edge of sys_clk.
*/
module rtc_osc_model (
  input wire logic sys_clk,
  output logic osc_stopped,
  output logic alarm_a_hit,
  output logic alarm_b_hit
);
  timeunit 1ns;
  timeprecision 1ps;
  // Oscillator running and no alarm match at start.
  initial
  begin
    osc_stopped = 1'b0;
    alarm_a_hit = 1'b0;
    alarm_b_hit = 1'b0;
  end
  // Stops the oscillator for n cycles, then lets it run again.
  task automatic halt(input int n);
    osc_stopped <= 1'b1;
    repeat (n) @(posedge sys_clk);
    osc_stopped <= 1'b0;
  endtask
  // A one-cycle match pulse, the shortest cause the core must catch.
  task automatic hit(input bit b);
    alarm_a_hit <= !b;
    alarm_b_hit <= b;
    @(posedge sys_clk);
    alarm_a_hit <= 1'b0;
    alarm_b_hit <= 1'b0;
  endtask
endmodule

// ===== rtc_pkg.sv
/*
  Shared types of the real-time clock core.
  Assumes the constants of rtc_regs.svh are included where needed.
*/
package rtc_pkg;
  typedef logic [7:0] rtc_byte_t;
  // Periodic interrupt cycle selection codes.
  typedef enum logic [2:0] {
    RTC_PM_OFF = 3'h0,
    RTC_PM_LOW = 3'h1,
    RTC_PM_P2HZ = 3'h2,
    RTC_PM_P1HZ = 3'h3,
    RTC_PM_SEC = 3'h4,
    RTC_PM_MIN = 3'h5,
    RTC_PM_HOUR = 3'h6,
    RTC_PM_MONTH = 3'h7
  } rtc_pmode_t;
endpackage

// ===== rtc_regs.svh
/*
  Register indices, field positions, calendar codes and timing counts
  for the real-time clock core. Assumes a 250 MHz system clock and a
  32-bit AXI4-Lite bus where byte address equals four times the index.
*/
// How it works
// - oscillator stop sets halt flag, held until cleared
// - halt flag forces control and trim bits zero, except hour format
// - halt releases interrupt A, clock on B
// - writing control two while running clears halt
// - clock gate zero enables crystal clock output
// - periodic flag mirrors asserted periodic interrupt output
// - level mode write zero clears periodic flag
// - enabled alarm match sets its match flag
// - write zero clears alarm flag, one ignored
// - disabled alarm reads match flag as zero
// - seconds count BCD 00..59, carry to minutes
// - minutes count BCD 00..59, carry to hours
// - hour wrap carries into day and weekday
// - weekday increments modulo seven on hour carry
// - day wraps per month length, carries month
// - month counts 1..12, carries into year
// - years divisible by four are leap years
// - hour bit five is pm or tens-twenty
// - format zero uses twelve-hour hour codes
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH
`define RTC_IDX_SEC 4'h0
`define RTC_IDX_MIN 4'h1
`define RTC_IDX_HOUR 4'h2
`define RTC_IDX_WDAY 4'h3
`define RTC_IDX_DAY 4'h4
`define RTC_IDX_MONTH 4'h5
`define RTC_IDX_YEAR 4'h6
`define RTC_IDX_TRIM 4'h7
`define RTC_IDX_CTRL1 4'hE
`define RTC_IDX_CTRL2 4'hF
`define RTC_MASK_SEC 8'h7F
`define RTC_MASK_HOUR 8'h3F
`define RTC_MASK_WDAY 8'h07
`define RTC_MASK_DAY 8'h3F
`define RTC_MASK_MONTH 8'h1F
`define RTC_BCD_ZERO 8'h00
`define RTC_BCD_59 8'h59
`define RTC_HR24_LAST 8'h23
`define RTC_HR12_AM12 8'h12
`define RTC_HR12_AM1 8'h01
`define RTC_HR12_AM11 8'h11
`define RTC_HR12_PM12 8'h32
`define RTC_HR12_PM1 8'h21
`define RTC_HR12_PM11 8'h31
`define RTC_DAY_FIRST 8'h01
`define RTC_DAY_31 8'h31
`define RTC_DAY_30 8'h30
`define RTC_DAY_29 8'h29
`define RTC_DAY_28 8'h28
`define RTC_MON_FEB 8'h02
`define RTC_MON_APR 8'h04
`define RTC_MON_JUN 8'h06
`define RTC_MON_SEP 8'h09
`define RTC_MON_NOV 8'h11
`define RTC_MONTH_LAST 8'h12
`define RTC_YEAR_LAST 8'h99
`define RTC_WDAY_LAST 3'h6
`define RTC_C2_FMT 5
`define RTC_C2_HALT 4
`define RTC_C2_GATE 3
`define RTC_C2_PIRQ 2
`define RTC_C2_AFA 1
`define RTC_C2_AFB 0
`define RTC_C1_AEA 7
`define RTC_C1_AEB 6
`define RTC_C1_RT_HI 5
`define RTC_C1_RT_LO 4
`define RTC_C1_TEST 3
`define RTC_C1_CT_HI 2
`define RTC_RESP_OKAY 2'h0
`define RTC_RESP_SLVERR 2'h2
`define RTC_CLK_HZ 250000000
`define RTC_SECOND_S 1
`define RTC_CLKS_PER_SEC (`RTC_SECOND_S * `RTC_CLK_HZ)
`define RTC_XTAL_HZ 32768
`define RTC_CLK32_HALF (`RTC_CLK_HZ / (`RTC_XTAL_HZ * 2))
`endif

// ===== rtc_status_flags_and_calendar_tb.sv
/*
  Self-checking bench for the clock core: register tasks on AXI4-Lite,
  calendar rollovers, flags, clock output gate and oscillator halt.
  Assumes a second shortened to 64 cycles and the far-side model.
*/
`include "rtc_regs.svh"
module rtc_status_flags_and_calendar_tb import rtc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SEC = 64;
  localparam int C1 = `RTC_IDX_CTRL1;
  localparam int C2 = `RTC_IDX_CTRL2;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b1;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b1;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic osc_stopped, alarm_a_hit, alarm_b_hit, irq_out_a_out, irq_out_a_oe;
  logic irq_out_b_out, irq_out_b_oe, clk32_out, test_mode;
  int n_fail = 0;
  int comparisons = 0;
  rtc_core #(.CLKS_PER_SEC(SEC)) rtc_core_inst (.*);
  rtc_osc_model rtc_osc_model_inst (.*);
  // A 4 ns clock period.
  always #2 sys_clk = ~sys_clk;
  // Counts a comparison and reports a mismatch at once.
  task automatic chk(input rtc_byte_t got, input rtc_byte_t exp);
    comparisons++;
    if (got !== exp)
      begin
        n_fail++;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
  endtask
  // Write: address and data offered together, each released when taken.
  task automatic wr(input int idx, input rtc_byte_t d);
    s_axi_awaddr <= {idx[5:0], 2'b00};
    s_axi_wdata <= {24'h000000, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    do
      begin
        @(posedge sys_clk);
        if (s_axi_awready)
          s_axi_awvalid <= 1'b0;
        if (s_axi_wready)
          s_axi_wvalid <= 1'b0;
      end
    while (s_axi_awvalid || s_axi_wvalid);
    do
      @(posedge sys_clk);
    while (s_axi_bvalid !== 1'b1);
  endtask
  // Read: request held until taken; bready and rready stay high, so calls never toggle them.
  task automatic rd(input int idx, output rtc_byte_t d, output logic [1:0] r);
    s_axi_araddr <= {idx[5:0], 2'b00};
    s_axi_arvalid <= 1'b1;
    do
      @(posedge sys_clk);
    while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do
      @(posedge sys_clk);
    while (s_axi_rvalid !== 1'b1);
    d = s_axi_rdata[7:0];
    r = s_axi_rresp;
  endtask
  // Reads a register and compares its byte.
  task automatic rc(input int idx, input rtc_byte_t e);
    rtc_byte_t d;
    logic [1:0] r;
    rd(idx, d, r);
    chk(d, e);
  endtask
  // Polls until ctrl2 leaves value v, so checks land just after an event.
  task automatic poll(input rtc_byte_t v, output rtc_byte_t d);
    logic [1:0] r;
    d = v;
    for (int n = 0; n < 60 && d === v; n++)
      rd(C2, d, r);
  endtask
  // Sets 59:59 at the given hour and date, waits one second, checks all.
  task automatic roll(input rtc_byte_t fm, hr, dy, mo, yr, ehr, edy, emo, eyr);
    rtc_byte_t d;
    logic [1:0] r;
    wr(C2, fm);
    wr(`RTC_IDX_YEAR, yr);
    wr(`RTC_IDX_MONTH, mo);
    wr(`RTC_IDX_DAY, dy);
    wr(`RTC_IDX_WDAY, 8'h06);
    wr(`RTC_IDX_HOUR, hr);
    wr(`RTC_IDX_MIN, 8'h59);
    wr(`RTC_IDX_SEC, 8'h59);
    d = 8'h59;
    for (int n = 0; n < 60 && d === 8'h59; n++)
      rd(`RTC_IDX_SEC, d, r);
    chk(d, 8'h00);
    rc(`RTC_IDX_MIN, 8'h00);
    rc(`RTC_IDX_HOUR, ehr);
    rc(`RTC_IDX_WDAY, 8'h00);
    rc(`RTC_IDX_DAY, edy);
    rc(`RTC_IDX_MONTH, emo);
    rc(`RTC_IDX_YEAR, eyr);
  endtask
  // Prints the verdict and ends the run.
  task automatic final_report();
    if (n_fail == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Main sequence; the rollover cases end on the awkward month and year edges.
  initial
  begin
    rtc_byte_t d;
    logic [1:0] r;
    int t;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    rc(C2, 8'h10);
    wr(C1, 8'hF7);
    rc(C1, 8'h00);
    rc(`RTC_IDX_TRIM, 8'h00);
    wr(C2, 8'h00);
    rc(C2, 8'h00);
    for (int g = 0; g < 2; g++)
    begin
      wr(C2, g ? 8'h08 : 8'h00);
      t = 0;
      repeat (8000)
      begin
        @(posedge sys_clk);
        t += int'(clk32_out === 1'b1) + 2 * int'(irq_out_b_oe === 1'b1);
      end
      chk(8'(t > 0), 8'(g == 0));
    end
    wr(`RTC_IDX_DAY, 8'hC5);
    rc(`RTC_IDX_DAY, 8'h05);
    rd(8, d, r);
    chk({d[5:0], r}, {6'h00, `RTC_RESP_SLVERR});
    wr(C1, 8'h06);
    roll(8'h20, 8'h23, 8'h28, 8'h02, 8'h04, 8'h00, 8'h29, 8'h02, 8'h04);
    rc(C2, 8'h24);
    roll(8'h20, 8'h23, 8'h28, 8'h02, 8'h01, 8'h00, 8'h01, 8'h03, 8'h01);
    wr(C1, 8'h05);
    roll(8'h20, 8'h23, 8'h30, 8'h04, 8'h01, 8'h00, 8'h01, 8'h05, 8'h01);
    rc(C2, 8'h24);
    roll(8'h20, 8'h23, 8'h31, 8'h12, 8'h99, 8'h00, 8'h01, 8'h01, 8'h00);
    wr(C1, 8'h07);
    roll(8'h00, 8'h31, 8'h29, 8'h02, 8'h00, 8'h12, 8'h01, 8'h03, 8'h00);
    rc(C2, 8'h04);
    wr(C1, 8'h00);
    wr(C1, 8'h04);
    poll(8'h00, d);
    chk(d, 8'h04);
    chk({7'h00, irq_out_a_oe}, 8'h01);
    wr(C2, 8'h04);
    rc(C2, 8'h04);
    wr(C2, 8'h00);
    rc(C2, 8'h00);
    chk({7'h00, irq_out_a_oe}, 8'h00);
    wr(C1, 8'h01);
    rc(C2, 8'h04);
    for (int m = 2; m < 4; m++)
    begin
      wr(C1, 8'(m));
      poll(8'h04, d);
      chk(d, 8'h00);
      poll(8'h00, d);
      chk(d, 8'h04);
    end
    for (int b = 0; b < 2; b++)
    begin
      wr(C1, b ? 8'h40 : 8'h80);
      rtc_osc_model_inst.hit(b);
      rc(C2, b ? 8'h01 : 8'h02);
      wr(C2, b ? 8'h01 : 8'h02);
      rc(C2, b ? 8'h01 : 8'h02);
      wr(C2, 8'h00);
      rc(C2, 8'h00);
      chk({7'h00, irq_out_a_oe}, 8'h00);
      wr(C1, 8'h00);
      rtc_osc_model_inst.hit(b);
      rc(C2, 8'h00);
    end
    wr(C1, 8'h80);
    rtc_osc_model_inst.hit(1'b0);
    rc(C2, 8'h02);
    rtc_osc_model_inst.halt(10);
    rc(C2, 8'h10);
    rc(C1, 8'h00);
    chk({7'h00, irq_out_a_oe}, 8'h00);
    t = 0;
    repeat (8000)
    begin
      @(posedge sys_clk);
      t += int'(irq_out_b_oe === 1'b1);
    end
    chk(8'(t > 3000 && t < 5000), 8'h01);
    final_report();
  end
  // Cuts a hang short well beyond the expected run of some 25000 cycles.
  initial
  begin
    repeat (60000) @(posedge sys_clk);
    n_fail++;
    final_report();
  end
endmodule
